// *** hdl/rti_pkg.sv ***
// Package for the ripple timer: register offsets, field layout, reset values and chain taps.
// Assumes a single bus clock domain; the bus clock enable stands for the clock-select output.
package rti_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COUNT_VALUE    = 8'h09;

  // Control and status field positions
  localparam int BIT_OVERFLOW_FLAG   = 7;
  localparam int BIT_PERIODIC_FLAG   = 6;
  localparam int BIT_OVERFLOW_EN     = 5;
  localparam int BIT_PERIODIC_EN     = 4;
  localparam int BIT_OVERFLOW_ACK    = 3;
  localparam int BIT_PERIODIC_ACK    = 2;
  localparam int BIT_RATE_HI         = 1;
  localparam int BIT_RATE_LO         = 0;

  // Reset values
  localparam logic [1:0] RATE_RESET  = 2'h3;
  localparam logic [7:0] READ_ZERO   = 8'h00;

  // Chain layout: 2 prescaler bits, 8 counter bits, then the upper stages
  localparam int PRESCALE_BITS = 2;
  localparam int COUNT_BITS    = 8;
  localparam int CHAIN_BITS    = 17;
  localparam int TAP_PERIODIC_BASE = 13;

  // Power-on release after this many bus clock periods
  localparam int POR_CYCLES    = 4064;

  // Power-on sequence states
  typedef enum logic [1:0] {
    RTI_POR_COUNT   = 2'b00,
    RTI_POR_RELEASE = 2'b01,
    RTI_RUN         = 2'b10
  } rti_por_state_t;

endpackage : rti_pkg

// *** hdl/rti_regfile.sv ***
// Control and status register of the ripple timer: flags, enables, rate select.
// Assumes one-cycle write strobes from the register port and event pulses from the chain.
`timescale 1ns/1ps
`default_nettype none

module rti_regfile (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_clear,
  // Software write
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  // Events from the chain
  input  wire logic       i_overflow_evt,
  input  wire logic       i_periodic_evt,
  // State
  output logic            o_overflow_flag,
  output logic            o_periodic_irq_flag,
  output logic            o_overflow_irq_enable,
  output logic            o_periodic_irq_enable,
  output logic [1:0]      o_periodic_rate_select
);

  logic overflow_ack;
  logic periodic_ack;

  assign overflow_ack = i_wr && i_wdata[rti_pkg::BIT_OVERFLOW_ACK];
  assign periodic_ack = i_wr && i_wdata[rti_pkg::BIT_PERIODIC_ACK];

  // Set wins over a simultaneous acknowledge so no event is lost
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || i_clear) begin
      o_overflow_flag <= 1'b0;
    end else if (i_overflow_evt) begin
      o_overflow_flag <= 1'b1;
    end else if (overflow_ack) begin
      o_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || i_clear) begin
      o_periodic_irq_flag <= 1'b0;
    end else if (i_periodic_evt) begin
      o_periodic_irq_flag <= 1'b1;
    end else if (periodic_ack) begin
      o_periodic_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || i_clear) begin
      o_overflow_irq_enable  <= 1'b0;
      o_periodic_irq_enable  <= 1'b0;
      o_periodic_rate_select <= rti_pkg::RATE_RESET;
    end else if (i_wr) begin
      o_overflow_irq_enable  <= i_wdata[rti_pkg::BIT_OVERFLOW_EN];
      o_periodic_irq_enable  <= i_wdata[rti_pkg::BIT_PERIODIC_EN];
      o_periodic_rate_select <= i_wdata[rti_pkg::BIT_RATE_HI:rti_pkg::BIT_RATE_LO];
    end
  end

endmodule : rti_regfile

`default_nettype wire

// *** hdl/rti_timer.sv ***
// Ripple timer top: prescaler, 8-bit counter, power-on delay stages, periodic interrupt taps,
// register port at the control/status and count offsets.
// Assumes i_bus_clk_en is the clock-select output as a one-cycle enable per bus clock period,
// held low in stop mode; i_ext_reset is already synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none

module rti_timer #(
  parameter int POR_CYCLES = rti_pkg::POR_CYCLES
) (
  // Clock and reset (i_reset_n acts as power-on reset)
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Timer clock and external reset
  input  wire logic       i_bus_clk_en,
  input  wire logic       i_ext_reset,
  input  wire logic       i_stop_mode,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Status outputs
  output logic            o_irq,
  output logic            o_por_active,
  output logic      [7:0] o_count_value
);

  localparam int CW = rti_pkg::CHAIN_BITS;
  localparam int PB = rti_pkg::PRESCALE_BITS;
  localparam int CB = rti_pkg::COUNT_BITS;

  initial begin
    if (POR_CYCLES < 2 || POR_CYCLES >= (1 << CW)) begin
      $error("rti_timer: POR_CYCLES out of range");
    end
  end

  // Whole chain: [1:0] prescaler, [9:2] counter, [16:10] upper stages
  logic [CW-1:0]  chain;
  logic [CW-1:0]  next_chain;
  logic           tick;
  logic           chain_clear;
  logic           overflow_evt;
  logic           periodic_evt;
  logic [1:0]     rate;
  logic           ovf_flag;
  logic           per_flag;
  logic           ovf_en;
  logic           per_en;
  logic           ctrl_wr;
  logic [7:0]     status_byte;
  rti_pkg::rti_por_state_t por_state;

  // Stop mode halts the timer clock; register contents are untouched
  assign tick = i_bus_clk_en && !i_stop_mode;

  assign next_chain = chain + {{(CW-1){1'b0}}, 1'b1};

  // Selected tap output rising: stage 13+rate going high
  function automatic logic tap_rises(input logic [CW-1:0] cur, input logic [CW-1:0] nxt,
                                     input logic [1:0] sel);
    int idx;
    idx = rti_pkg::TAP_PERIODIC_BASE + int'(sel);
    tap_rises = !cur[idx] && nxt[idx];
  endfunction : tap_rises

  function automatic logic cur_count_wraps(input logic [CW-1:0] cur);
    cur_count_wraps = &cur[PB+CB-1:0];
  endfunction : cur_count_wraps

  // Counter wrap shows as the last counter stage falling
  assign overflow_evt = tick && (por_state == rti_pkg::RTI_RUN) && !i_ext_reset
                        && cur_count_wraps(chain);
  assign periodic_evt = tick && (por_state == rti_pkg::RTI_RUN) && !i_ext_reset
                        && tap_rises(chain, next_chain, rate);

  // Power-on sequencer: count bus clocks, release, then run
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      por_state <= rti_pkg::RTI_POR_COUNT;
    end else begin
      case (por_state)
        rti_pkg::RTI_POR_COUNT: begin
          if (tick && chain == CW'(POR_CYCLES - 1)) begin
            por_state <= rti_pkg::RTI_POR_RELEASE;
          end
        end
        rti_pkg::RTI_POR_RELEASE: begin
          por_state <= rti_pkg::RTI_RUN;
        end
        rti_pkg::RTI_RUN: begin
          por_state <= rti_pkg::RTI_RUN;
        end
        default: begin
          por_state <= rti_pkg::RTI_POR_COUNT;
        end
      endcase
    end
  end

  // Second clear at release; external reset clears the chain outside power-on
  assign chain_clear = (por_state == rti_pkg::RTI_POR_RELEASE)
                       || (por_state == rti_pkg::RTI_RUN && i_ext_reset);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      chain <= '0;
    end else if (chain_clear) begin
      chain <= '0;
    end else if (tick) begin
      chain <= next_chain;
    end
  end

  // Register block is cleared by power-on and by external reset
  assign ctrl_wr = i_wr && (i_addr == rti_pkg::ADDR_CONTROL_STATUS);

  rti_regfile u_regfile (
    .i_clk                  (i_clk),
    .i_reset_n              (i_reset_n),
    .i_clear                (i_ext_reset || por_state != rti_pkg::RTI_RUN),
    .i_wr                   (ctrl_wr),
    .i_wdata                (i_wdata),
    .i_overflow_evt         (overflow_evt),
    .i_periodic_evt         (periodic_evt),
    .o_overflow_flag        (ovf_flag),
    .o_periodic_irq_flag    (per_flag),
    .o_overflow_irq_enable  (ovf_en),
    .o_periodic_irq_enable  (per_en),
    .o_periodic_rate_select (rate)
  );

  // Acknowledge bits always read as zero
  always_comb begin
    status_byte = rti_pkg::READ_ZERO;
    status_byte[rti_pkg::BIT_OVERFLOW_FLAG] = ovf_flag;
    status_byte[rti_pkg::BIT_PERIODIC_FLAG] = per_flag;
    status_byte[rti_pkg::BIT_OVERFLOW_EN]   = ovf_en;
    status_byte[rti_pkg::BIT_PERIODIC_EN]   = per_en;
    status_byte[rti_pkg::BIT_RATE_HI]       = rate[1];
    status_byte[rti_pkg::BIT_RATE_LO]       = rate[0];
  end

  // Read data stand one cycle after the strobe and only then
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !i_rd) begin
      o_rdata <= rti_pkg::READ_ZERO;
    end else if (i_addr == rti_pkg::ADDR_CONTROL_STATUS) begin
      o_rdata <= status_byte;
    end else if (i_addr == rti_pkg::ADDR_COUNT_VALUE) begin
      o_rdata <= chain[PB+CB-1:PB];
    end else begin
      o_rdata <= rti_pkg::READ_ZERO;
    end
  end

  // Registered request; one cycle late relative to the flags
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (ovf_flag && ovf_en) || (per_flag && per_en);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_por_active  <= 1'b1;
      o_count_value <= rti_pkg::READ_ZERO;
    end else begin
      o_por_active  <= (por_state != rti_pkg::RTI_RUN);
      o_count_value <= chain[PB+CB-1:PB];
    end
  end

endmodule : rti_timer

`default_nettype wire

// *** tb/rti_timer_sva.sv ***
// Checker for the ripple timer top: read port, count hold and clear, interrupt gating, power-on.
// Assumes one clock domain; attached by the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module rti_timer_sva #(
  parameter int POR_CYCLES = 4064
) (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  // Timer control
  input wire logic       i_bus_clk_en,
  input wire logic       i_ext_reset,
  input wire logic       i_stop_mode,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // Status
  input wire logic       o_irq,
  input wire logic       o_por_active,
  input wire logic [7:0] o_count_value
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic run = !o_por_active && !i_ext_reset;

  rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data not idle");
  ack_reads_zero_a: assert property (i_rd && i_addr == 8'h08 |=> o_rdata[3:2] == 2'h0)
    else $error("ack bits read nonzero");
  unmapped_zero_a: assert property (i_rd && i_addr != 8'h08 && i_addr != 8'h09 |=> o_rdata == 8'h00)
    else $error("unmapped read nonzero");
  count_hold_a: assert property ((run && (i_stop_mode || !i_bus_clk_en))[*2] |=> $stable(o_count_value))
    else $error("count moved without tick");
  ext_clear_a: assert property (i_ext_reset && !o_por_active |=> ##1 o_count_value == 8'h00)
    else $error("count not cleared");
  irq_clear_a: assert property (i_ext_reset && !o_por_active |=> ##1 !o_irq) else $error("irq after reset");
  irq_gate_a: assert property (i_wr && i_addr == 8'h08 && i_wdata[5:4] == 2'h0 && run |=> ##1 !o_irq)
    else $error("irq with enables off");
  por_start_a: assert property ($rose(i_reset_n) |-> o_por_active) else $error("power-on not active");
  por_exit_zero_a: assert property ($fell(o_por_active) |-> o_count_value == 8'h00)
    else $error("count not zero at start");
endmodule : rti_timer_sva

bind rti_timer rti_timer_sva #(.POR_CYCLES(POR_CYCLES)) u_sva (.i_clk, .i_reset_n, .i_bus_clk_en, .i_ext_reset,
  .i_stop_mode, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .o_por_active, .o_count_value);
`default_nettype wire

// *** tb/rti_timer_tb.sv ***
// Testbench for the ripple timer: register port, counter, flags, stop and external reset.
// Assumes the checker is bound; a short power-on count keeps the run brief.
`timescale 1ns/1ps
`default_nettype none
module rti_timer_tb;
  localparam int POR = 16;
  logic        i_clk = 0, i_reset_n = 0, en = 0, ext = 0, stop = 0, wr = 0, rd = 0, rd_pend = 0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, d, rdata, cnt;
  logic        irq, por;
  logic [7:0]  exp_q[$];
  logic [31:0] seed = 32'hddda_6dd0;
  int          failures = 0, n_checks = 0, cyc = 0, w, chain;
  always #5 i_clk = ~i_clk;
  rti_timer #(.POR_CYCLES(POR)) dut (.i_clk, .i_reset_n, .i_bus_clk_en(en), .i_ext_reset(ext),
    .i_stop_mode(stop), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_irq(irq), .o_por_active(por), .o_count_value(cnt));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check_rd(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : check_rd
  task automatic check_bit(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask : check_bit
  task automatic report_and_stop;
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // Gap cycle after each strobe so no signal is assigned twice in one step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    @(posedge i_clk);
  endtask : rd_reg
  task automatic ticks(input int n);
    en <= 1'b1;
    repeat (n) @(posedge i_clk);
    en <= 1'b0;
    if (!stop)
      chain += n;
    @(posedge i_clk);
  endtask : ticks
  task automatic ext_pulse;
    ext <= 1'b1;
    @(posedge i_clk);
    ext <= 1'b0;
    chain = 0;
    @(posedge i_clk);
  endtask : ext_pulse
  always @(posedge i_clk) rd_pend <= rd;
  always @(negedge i_clk) begin
    if (rd_pend)
      check_rd("read data", exp_q.pop_front(), rdata);
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 70000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    en <= 1'b1;
    w = 0;
    do begin
      @(posedge i_clk);
      #1;
      w++;
    end while (por !== 1'b0 && w < 100);
    check_bit("power-on time", 1'b1, w >= POR && w <= POR + 4);
    en <= 1'b0;
    rd_reg(8'h08, 8'h03);
    rd_reg(8'h3c, 8'h00);
    ext_pulse();
    ticks(12);
    wr_reg(8'h09, 8'hff);
    rd_reg(8'h09, 8'(chain >> 2));
    check_rd("count value", 8'(chain >> 2), cnt);
    stop <= 1'b1;
    ticks(8);
    rd_reg(8'h09, 8'(chain >> 2));
    check_rd("count value", 8'(chain >> 2), cnt);
    stop <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      d = {seed[7:2], 2'(i)};
      wr_reg(8'h08, d);
      rd_reg(8'h08, {2'b00, d[5:4], 2'b00, d[1:0]});
    end
    ext_pulse();
    wr_reg(8'h08, 8'h20);
    ticks(1023);
    rd_reg(8'h08, 8'h20);
    ticks(1);
    rd_reg(8'h08, 8'ha0);
    check_bit("irq", 1'b1, irq);
    wr_reg(8'h08, 8'h20);
    rd_reg(8'h08, 8'ha0);
    wr_reg(8'h08, 8'h28);
    rd_reg(8'h08, 8'h20);
    check_bit("irq", 1'b0, irq);
    wr_reg(8'h08, 8'h10);
    ticks(8191 - chain);
    rd_reg(8'h08, 8'h90);
    check_bit("irq", 1'b0, irq);
    ticks(1);
    rd_reg(8'h08, 8'hd0);
    check_bit("irq", 1'b1, irq);
    wr_reg(8'h08, 8'h1c);
    ticks(16383);
    rd_reg(8'h08, 8'h90);
    ticks(1);
    rd_reg(8'h08, 8'hd0);
    wr_reg(8'h08, 8'h0c);
    rd_reg(8'h08, 8'h00);
    ext_pulse();
    rd_reg(8'h08, 8'h03);
    check_bit("irq", 1'b0, irq);
    // Rates 01 and 10, each changed while the chain stands far from its tap edge
    ext_pulse();
    wr_reg(8'h08, 8'h11);
    ticks(16383);
    rd_reg(8'h08, 8'h91);
    ticks(1);
    rd_reg(8'h08, 8'hd1);
    wr_reg(8'h08, 8'h1e);
    rd_reg(8'h08, 8'h12);
    ticks(16383);
    rd_reg(8'h08, 8'h92);
    ticks(1);
    rd_reg(8'h08, 8'hd2);
    check_bit("irq", 1'b1, irq);
    report_and_stop();
  end
endmodule : rti_timer_tb
`default_nettype wire
